//--- verilog/board_reset_pkg.sv
package board_reset_pkg;
  localparam int CLK_PERIOD_NS  = 40;
  localparam int POR_TIME_NS    = 100000;
  localparam int WARM_TIME_NS   = 10000;
  localparam int SETTLE_TIME_NS = 1000;
  localparam int POR_CYCLES     = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WARM_CYCLES    = (WARM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYCLES  = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [6:0] EXP_I2C_ADDR    = 7'h18;
  localparam logic [1:0] REG_INPUT       = 2'h0;
  localparam logic [1:0] REG_OUTPUT      = 2'h1;
  localparam logic [1:0] REG_POLARITY    = 2'h2;
  localparam logic [1:0] REG_DIRECTION   = 2'h3;
  localparam logic [7:0] OUTPUT_RESET    = 8'hFF;
  localparam logic [7:0] POLARITY_RESET  = 8'hF0;
  localparam logic [7:0] DIRECTION_RESET = 8'hFF;

  localparam logic [7:0] FBS_DEFAULT = 8'hC3;
  localparam logic [7:0] RWS_DEFAULT = 8'hEA;
  localparam int FB_SEQ_BIT   = 6;
  localparam int FB_BANK_BIT  = 7;
  localparam int RW_WIDTH_BIT = 0;
  localparam int RW_PERS_BIT  = 1;
  localparam int RW_DMA_BIT   = 2;
  localparam int RW_ROLE2_BIT = 3;
  localparam int RW_ROLE1_BIT = 6;
  localparam int RW_ROLE0_BIT = 7;

  localparam logic [3:0] PREFIX_533 = 4'hC;
  localparam logic [3:0] PREFIX_400 = 4'hD;
  localparam logic [3:0] PREFIX_667 = 4'h8;
  localparam logic [1:0] MODE_DUAL   = 2'h2;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [9:0] MHZ_533 = 10'h215;
  localparam logic [9:0] MHZ_400 = 10'h190;
  localparam logic [9:0] MHZ_667 = 10'h29B;
  localparam logic [9:0] MHZ_267 = 10'h10B;
  localparam logic [9:0] MHZ_333 = 10'h14D;

  typedef enum logic [1:0] {RST_START, RST_HOLD, RST_RUN} rst_state_t;
  typedef enum logic [3:0] {
    I_IDLE, I_ADDR, I_AACK, I_CMD, I_CACK, I_WDATA, I_WACK, I_RDATA, I_RACK
  } i2c_state_t;
endpackage

//--- verilog/board_reset_strap_override.sv
`timescale 1ns/1ps
`default_nettype none

module pin_filter #(
  parameter int         W     = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clock_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stage1  <= INIT;
      stage2  <= INIT;
      stage3  <= INIT;
      level_o <= INIT;
    end else begin
      stage1  <= pin_i;
      stage2  <= stage1;
      stage3  <= stage2;
      level_o <= (stage2 & stage3) | (level_o & (stage2 | stage3));
    end
  end
endmodule

module board_reset_strap_override
  import board_reset_pkg::*;
#(
  parameter int POR_LEN  = POR_CYCLES,
  parameter int WARM_LEN = WARM_CYCLES
) (
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  input  wire logic       power_switch_i,
  input  wire logic       warm_reset_button_n_i,
  input  wire logic       soft_reset_request_low_n_i,
  input  wire logic [7:0] frequency_boot_switch_bank_i,
  input  wire logic [7:0] role_width_switch_bank_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  output logic            por_n_o,
  output logic            hreset_n_o,
  output logic [1:0]      boot_source_o,
  output logic [9:0]      core_freq_mhz_o,
  output logic [9:0]      platform_mhz_o,
  output logic [9:0]      ddr_mhz_o,
  output logic            config_valid_o,
  output logic            dual_core_mode_o,
  output logic            dual_identity_o,
  output logic            boot_seq_enable_o,
  output logic            flash_bank_choice_o,
  output logic            card_bus_width_strap_o,
  output logic            spi_enable_o,
  output logic            pcie_role_pin_zero_o,
  output logic            pcie_role_pin_one_o,
  output logic            pcie_role_pin_two_o,
  output logic            pcie1_host_o,
  output logic            pcie2_host_o
);
  // ****************************************
  // Input filtering.
  // ****************************************
  logic [20:0] level;
  logic        pwr_f;
  logic        warm_n_f;
  logic        soft_n_f;
  logic        scl_f;
  logic        sda_f;
  logic [7:0]  fbs_f;
  logic [7:0]  rws_f;

  pin_filter #(
    .W    (21),
    .INIT ({1'b0, 1'b1, 1'b1, 1'b1, 1'b1, RWS_DEFAULT, FBS_DEFAULT})
  ) u_filter (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .pin_i    ({power_switch_i, warm_reset_button_n_i, soft_reset_request_low_n_i,
                scl_i, sda_i, role_width_switch_bank_i, frequency_boot_switch_bank_i}),
    .level_o  (level)
  );

  assign {pwr_f, warm_n_f, soft_n_f, scl_f, sda_f, rws_f, fbs_f} = level;

  logic pwr_q;
  logic warm_n_q;
  logic soft_n_q;
  logic scl_q;
  logic sda_q;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwr_q    <= 1'b0;
      warm_n_q <= 1'b1;
      soft_n_q <= 1'b1;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end else begin
      pwr_q    <= pwr_f;
      warm_n_q <= warm_n_f;
      soft_n_q <= soft_n_f;
      scl_q    <= scl_f;
      sda_q    <= sda_f;
    end
  end

  logic por_req;
  logic button_req;
  logic soft_req;

  assign por_req    = pwr_f & ~pwr_q;
  assign button_req = ~warm_n_f & warm_n_q;
  assign soft_req   = ~soft_n_f & soft_n_q;

  // ****************************************
  // Reset sequencer.
  // ****************************************
  rst_state_t  state;
  logic        is_por;
  logic [11:0] hold_cnt;
  logic [11:0] hold_last;

  assign hold_last = is_por ? 12'(POR_LEN - 1) : 12'(WARM_LEN - 1);

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state    <= RST_START;
      is_por   <= 1'b1;
      hold_cnt <= 12'h000;
    end else if (por_req) begin
      state  <= RST_START;
      is_por <= 1'b1;
    end else if ((button_req || soft_req) && state == RST_RUN) begin
      state  <= RST_START;
      is_por <= 1'b0;
    end else begin
      unique case (state)
        RST_START: begin
          state    <= RST_HOLD;
          hold_cnt <= 12'h000;
        end
        RST_HOLD: begin
          if (hold_cnt == hold_last) begin
            state <= RST_RUN;
          end else begin
            hold_cnt <= hold_cnt + 12'h001;
          end
        end
        RST_RUN: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hreset_n_o <= 1'b0;
      por_n_o    <= 1'b0;
    end else begin
      hreset_n_o <= (state == RST_RUN);
      por_n_o    <= !(state != RST_RUN && is_por);
    end
  end

  // ****************************************
  // Override expander registers.
  // ****************************************
  logic [7:0] pin_out;
  logic [7:0] pin_pol;
  logic [7:0] pin_dir;
  logic [7:0] eff_pin;
  logic [7:0] rd_data;
  logic       wr_pulse;
  logic [7:0] wr_data;
  logic [1:0] ptr;

  always_comb begin
    eff_pin[7:2] = {fbs_f[0], fbs_f[1], fbs_f[2], fbs_f[3], fbs_f[4], fbs_f[5]};
    eff_pin[1]   = fbs_f[FB_BANK_BIT];
    eff_pin[0]   = rws_f[RW_WIDTH_BIT];
    for (int k = 1; k < 8; k++) begin
      if (!pin_dir[k]) begin
        eff_pin[k] = pin_out[k];
      end
    end
  end

  always_comb begin
    unique case (ptr)
      REG_INPUT:     rd_data = eff_pin ^ pin_pol;
      REG_OUTPUT:    rd_data = pin_out;
      REG_POLARITY:  rd_data = pin_pol;
      REG_DIRECTION: rd_data = pin_dir;
    endcase
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_out <= OUTPUT_RESET;
      pin_pol <= POLARITY_RESET;
      pin_dir <= DIRECTION_RESET;
    end else if (por_req) begin
      pin_out <= OUTPUT_RESET;
      pin_pol <= POLARITY_RESET;
      pin_dir <= DIRECTION_RESET;
    end else if (wr_pulse) begin
      unique case (ptr)
        REG_INPUT:     begin end
        REG_OUTPUT:    pin_out <= wr_data;
        REG_POLARITY:  pin_pol <= wr_data;
        REG_DIRECTION: pin_dir <= wr_data;
      endcase
    end
  end

  // ****************************************
  // I2C slave.
  // ****************************************
  i2c_state_t ist;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] tx;
  logic       rw;
  logic       nack;
  logic       start_ev;
  logic       stop_ev;
  logic       rise_ev;
  logic       fall_ev;

  assign start_ev = scl_f & scl_q & sda_q & ~sda_f;
  assign stop_ev  = scl_f & scl_q & ~sda_q & sda_f;
  assign rise_ev  = scl_f & ~scl_q;
  assign fall_ev  = ~scl_f & scl_q;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ist      <= I_IDLE;
      bit_cnt  <= 4'h0;
      shift    <= 8'h00;
      tx       <= 8'h00;
      rw       <= 1'b0;
      nack     <= 1'b0;
      ptr      <= REG_INPUT;
      sda_oe_o <= 1'b0;
      wr_pulse <= 1'b0;
      wr_data  <= 8'h00;
    end else begin
      wr_pulse <= 1'b0;
      if (start_ev) begin
        ist      <= I_ADDR;
        bit_cnt  <= 4'h0;
        sda_oe_o <= 1'b0;
      end else if (stop_ev) begin
        ist      <= I_IDLE;
        sda_oe_o <= 1'b0;
      end else if (rise_ev) begin
        if (ist == I_ADDR || ist == I_CMD || ist == I_WDATA) begin
          shift   <= {shift[6:0], sda_f};
          bit_cnt <= bit_cnt + 4'h1;
        end else if (ist == I_RDATA) begin
          bit_cnt <= bit_cnt + 4'h1;
        end else if (ist == I_RACK) begin
          nack <= sda_f;
        end
      end else if (fall_ev) begin
        unique case (ist)
          I_IDLE: begin end
          I_ADDR: begin
            if (bit_cnt == 4'h8) begin
              if (shift[7:1] == EXP_I2C_ADDR) begin
                ist      <= I_AACK;
                sda_oe_o <= 1'b1;
                rw       <= shift[0];
              end else begin
                ist <= I_IDLE;
              end
            end
          end
          I_AACK: begin
            bit_cnt <= 4'h0;
            if (rw) begin
              tx       <= rd_data;
              sda_oe_o <= ~rd_data[7];
              ist      <= I_RDATA;
            end else begin
              sda_oe_o <= 1'b0;
              ist      <= I_CMD;
            end
          end
          I_CMD: begin
            if (bit_cnt == 4'h8) begin
              ptr      <= shift[1:0];
              sda_oe_o <= 1'b1;
              ist      <= I_CACK;
            end
          end
          I_CACK, I_WACK: begin
            sda_oe_o <= 1'b0;
            bit_cnt  <= 4'h0;
            ist      <= I_WDATA;
          end
          I_WDATA: begin
            if (bit_cnt == 4'h8) begin
              wr_pulse <= 1'b1;
              wr_data  <= shift;
              sda_oe_o <= 1'b1;
              ist      <= I_WACK;
            end
          end
          I_RDATA: begin
            if (bit_cnt == 4'h8) begin
              sda_oe_o <= 1'b0;
              ist      <= I_RACK;
            end else begin
              sda_oe_o <= ~tx[6];
              tx       <= {tx[6:0], 1'b0};
            end
          end
          I_RACK: begin
            if (nack) begin
              ist <= I_IDLE;
            end else begin
              tx       <= rd_data;
              sda_oe_o <= ~rd_data[7];
              bit_cnt  <= 4'h0;
              ist      <= I_RDATA;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  // ****************************************
  // Strap decode and latch.
  // ****************************************
  logic [5:0] field;
  logic [1:0] mode;
  logic [9:0] next_core;
  logic [9:0] next_platform;
  logic       next_valid;

  assign field = eff_pin[7:2];
  assign mode  = {rws_f[RW_PERS_BIT], rws_f[RW_DMA_BIT]};

  always_comb begin
    next_core     = MHZ_533;
    next_platform = MHZ_267;
    next_valid    = 1'b0;
    if (field[5:2] == PREFIX_533 || field[5:2] == PREFIX_400) begin
      next_core  = (field[5:2] == PREFIX_533) ? MHZ_533 : MHZ_400;
      next_valid = (mode == MODE_DUAL) || (mode == MODE_SINGLE);
    end else if (field[5:2] == PREFIX_667) begin
      next_core     = MHZ_667;
      next_platform = MHZ_333;
      next_valid    = (mode == MODE_SINGLE);
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      boot_source_o          <= 2'h0;
      core_freq_mhz_o        <= MHZ_533;
      platform_mhz_o         <= MHZ_267;
      ddr_mhz_o              <= MHZ_667;
      config_valid_o         <= 1'b1;
      dual_core_mode_o       <= 1'b1;
      dual_identity_o        <= 1'b1;
      boot_seq_enable_o      <= 1'b0;
      flash_bank_choice_o    <= 1'b1;
      card_bus_width_strap_o <= 1'b0;
      spi_enable_o           <= 1'b1;
      pcie_role_pin_zero_o   <= 1'b1;
      pcie_role_pin_one_o    <= 1'b1;
      pcie_role_pin_two_o    <= 1'b1;
      pcie1_host_o           <= 1'b1;
      pcie2_host_o           <= 1'b1;
    end else if (state == RST_START) begin
      boot_source_o          <= field[1:0];
      core_freq_mhz_o        <= next_core;
      platform_mhz_o         <= next_platform;
      ddr_mhz_o              <= MHZ_667;
      config_valid_o         <= next_valid;
      dual_core_mode_o       <= (mode == MODE_DUAL);
      dual_identity_o        <= rws_f[RW_PERS_BIT];
      boot_seq_enable_o      <= ~fbs_f[FB_SEQ_BIT];
      flash_bank_choice_o    <= eff_pin[1];
      card_bus_width_strap_o <= rws_f[RW_WIDTH_BIT];
      spi_enable_o           <= ~rws_f[RW_WIDTH_BIT];
      pcie_role_pin_zero_o   <= rws_f[RW_ROLE0_BIT];
      pcie_role_pin_one_o    <= rws_f[RW_ROLE1_BIT];
      pcie_role_pin_two_o    <= rws_f[RW_ROLE2_BIT];
      pcie1_host_o           <= rws_f[RW_ROLE1_BIT];
      pcie2_host_o           <= rws_f[RW_ROLE2_BIT];
    end
  end

  // ****************************************
  // Assertions.
  // ****************************************
  property p_por_press;
    @(posedge clock_i) disable iff (!resetn_i)
      por_req |-> ##2 (!por_n_o && !hreset_n_o);
  endproperty
  a_por_press: assert property (p_por_press) else $error("power press gave no reset");

  property p_button;
    @(posedge clock_i) disable iff (!resetn_i)
      button_req && state == RST_RUN && !por_req |-> ##2 (!hreset_n_o && por_n_o);
  endproperty
  a_button: assert property (p_button) else $error("button gave no warm reset");

  property p_soft;
    @(posedge clock_i) disable iff (!resetn_i)
      soft_req && state == RST_RUN && !por_req |-> ##1 (state == RST_START) ##1 !hreset_n_o;
  endproperty
  a_soft: assert property (p_soft) else $error("soft request gave no warm reset");

  property p_hold_stable;
    @(posedge clock_i) disable iff (!resetn_i)
      state == RST_HOLD && $past(state == RST_HOLD)
        |-> $stable(flash_bank_choice_o) && $stable(boot_source_o) && !hreset_n_o;
  endproperty
  a_hold_stable: assert property (p_hold_stable) else $error("straps moved in reset");

  property p_release_late;
    @(posedge clock_i) disable iff (!resetn_i)
      $rose(hreset_n_o) |-> $past(hold_cnt, 2) >= 12'(WARM_LEN - 2);
  endproperty
  a_release_late: assert property (p_release_late) else $error("reset released early");

  property p_override;
    @(posedge clock_i) disable iff (!resetn_i)
      state == RST_START && !pin_dir[1] |=> flash_bank_choice_o == $past(pin_out[1]);
  endproperty
  a_override: assert property (p_override) else $error("override not applied");

  property p_boot_source;
    @(posedge clock_i) disable iff (!resetn_i)
      state == RST_START |=> boot_source_o == $past(eff_pin[3:2]);
  endproperty
  a_boot_source: assert property (p_boot_source) else $error("boot source wrong");

  property p_freq_400;
    @(posedge clock_i) disable iff (!resetn_i)
      state == RST_START && field[5:2] == PREFIX_400
        |=> core_freq_mhz_o == MHZ_400 && platform_mhz_o == MHZ_267;
  endproperty
  a_freq_400: assert property (p_freq_400) else $error("400 MHz decode wrong");

  property p_roles;
    @(posedge clock_i) disable iff (!resetn_i)
      state == RST_START |=> pcie1_host_o == $past(rws_f[RW_ROLE1_BIT])
        && pcie2_host_o == $past(rws_f[RW_ROLE2_BIT])
        && pcie_role_pin_zero_o == $past(rws_f[RW_ROLE0_BIT]);
  endproperty
  a_roles: assert property (p_roles) else $error("pcie role decode wrong");

  property p_width;
    @(posedge clock_i) disable iff (!resetn_i)
      state == RST_START |=> card_bus_width_strap_o == $past(rws_f[RW_WIDTH_BIT])
        && spi_enable_o != card_bus_width_strap_o;
  endproperty
  a_width: assert property (p_width) else $error("width strap wrong");

  property p_por_clears;
    @(posedge clock_i) disable iff (!resetn_i)
      por_req |=> pin_dir == DIRECTION_RESET && pin_pol == POLARITY_RESET;
  endproperty
  a_por_clears: assert property (p_por_clears) else $error("expander not cleared");

  property p_stop_release;
    @(posedge clock_i) disable iff (!resetn_i)
      stop_ev |=> !sda_oe_o && ist == I_IDLE;
  endproperty
  a_stop_release: assert property (p_stop_release) else $error("sda held after stop");
endmodule

`default_nettype wire

//--- verif/i2c_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********************
// Host on the expander bus.
// ********************
module i2c_host_model (
  input  wire logic clock_i,
  input  wire logic sda_oe_i,
  output logic      scl_o,
  output logic      sda_o
);
  logic drv;
  // The line has a pull-up, so it is low while either party pulls it.
  assign sda_o = drv & ~sda_oe_i;
  initial begin
    drv = 1'b1;
    scl_o = 1'b1;
  end
  task automatic hold();
    repeat (8) @(posedge clock_i);
  endtask
  task automatic put(input logic b, output logic r);
    drv <= b;
    hold();
    scl_o <= 1'b1;
    hold();
    r = sda_o;
    scl_o <= 1'b0;
    hold();
  endtask
  task automatic start();
    drv <= 1'b1;
    hold();
    scl_o <= 1'b1;
    hold();
    drv <= 1'b0;
    hold();
    scl_o <= 1'b0;
    hold();
  endtask
  task automatic stop();
    drv <= 1'b0;
    hold();
    scl_o <= 1'b1;
    hold();
    drv <= 1'b1;
    hold();
  endtask
  // Bytes go most significant bit first; the ninth bit is the acknowledge.
  task automatic xbyte(input logic [7:0] d, input logic ackb, output logic [7:0] r,
                       output logic a);
    for (int i = 7; i >= 0; i--) begin
      put(d[i], r[i]);
    end
    put(ackb, a);
  endtask
endmodule
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import board_reset_pkg::*;
  logic       clock_i = 1'b0;
  logic       resetn_i = 1'b0;
  logic       pwr = 1'b0;
  logic       btn_n = 1'b1;
  logic       soft_n = 1'b1;
  logic [7:0] fb = 8'hC3;
  logic [7:0] rw = 8'hEA;
  logic       scl, sda, sda_o, sda_oe, por_n, hrst_n, cv, dm, di, se, fbk, cw, spi;
  logic       r0, r1, r2, h1, h2;
  logic [1:0] boot;
  logic [9:0] core, plat, ddr;
  int         errors = 0;
  int         num_checks = 0;
  always #20 clock_i = ~clock_i;
  board_reset_strap_override #(.POR_LEN(40), .WARM_LEN(20)) board_reset_strap_override_inst (
    .clock_i(clock_i), .resetn_i(resetn_i), .power_switch_i(pwr),
    .warm_reset_button_n_i(btn_n), .soft_reset_request_low_n_i(soft_n),
    .frequency_boot_switch_bank_i(fb), .role_width_switch_bank_i(rw),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .por_n_o(por_n),
    .hreset_n_o(hrst_n), .boot_source_o(boot), .core_freq_mhz_o(core),
    .platform_mhz_o(plat), .ddr_mhz_o(ddr), .config_valid_o(cv), .dual_core_mode_o(dm),
    .dual_identity_o(di), .boot_seq_enable_o(se), .flash_bank_choice_o(fbk),
    .card_bus_width_strap_o(cw), .spi_enable_o(spi), .pcie_role_pin_zero_o(r0),
    .pcie_role_pin_one_o(r1), .pcie_role_pin_two_o(r2), .pcie1_host_o(h1),
    .pcie2_host_o(h2));
  i2c_host_model i2c_host_model_inst (
    .clock_i(clock_i), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
  // ********************
  // Checking and reporting.
  // ********************
  task automatic check_val(input string what, input logic [9:0] exp, input logic [9:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check_cfg(input logic [1:0] b, input logic [9:0] c, input logic [9:0] p,
                           input logic v, input logic d, input logic i, input logic s,
                           input logic k, input logic w, input logic [2:0] ro,
                           input logic [1:0] ho);
    check_val("boot", b, boot);
    check_val("core", c, core);
    check_val("platform", p, plat);
    check_val("ddr", MHZ_667, ddr);
    check_val("valid", v, cv);
    check_val("dual", d, dm);
    check_val("identity", i, di);
    check_val("sequencer", s, se);
    check_val("bank", k, fbk);
    check_val("width", w, cw);
    check_val("spi", !w, spi);
    check_val("roles", ro, {r0, r1, r2});
    check_val("hosts", ho, {h1, h2});
  endtask
  // ********************
  // Reset requests: 0 power, 1 button, 2 soft request.
  // ********************
  task automatic pulse(input int which);
    int lo, plo, n;
    lo = 0;
    plo = 0;
    if (which == 0) pwr <= 1'b1;
    if (which == 1) btn_n <= 1'b0;
    if (which == 2) soft_n <= 1'b0;
    for (n = 0; n < 400; n++) begin
      @(posedge clock_i);
      if (n == 6) begin
        pwr <= 1'b0;
        btn_n <= 1'b1;
        soft_n <= 1'b1;
      end
      if (hrst_n === 1'b0) lo++;
      if (por_n === 1'b0) plo++;
      if (lo > 0 && hrst_n === 1'b1) break;
    end
    if (n == 400) begin
      errors++;
      close_out();
    end
    check_val("reset length", (which == 0) ? 41 : 21, lo);
    check_val("por length", (which == 0) ? 41 : 0, plo);
  endtask
  task automatic apply(input logic [7:0] f, input logic [7:0] r, input int which);
    fb <= f;
    rw <= r;
    repeat (6) @(posedge clock_i);
    pulse(which);
  endtask
  task automatic reg_write(input logic [6:0] a, input logic [1:0] p, input logic [7:0] d);
    logic [7:0] x;
    logic       k;
    i2c_host_model_inst.start();
    i2c_host_model_inst.xbyte({a, 1'b0}, 1'b1, x, k);
    check_val("address ack", a == EXP_I2C_ADDR, !k);
    if (!k) begin
      i2c_host_model_inst.xbyte({6'h00, p}, 1'b1, x, k);
      i2c_host_model_inst.xbyte(d, 1'b1, x, k);
    end
    i2c_host_model_inst.stop();
  endtask
  task automatic reg_check(input logic [1:0] p, input logic [7:0] e);
    logic [7:0] x;
    logic       k;
    i2c_host_model_inst.start();
    i2c_host_model_inst.xbyte(8'h30, 1'b1, x, k);
    i2c_host_model_inst.xbyte({6'h00, p}, 1'b1, x, k);
    i2c_host_model_inst.start();
    i2c_host_model_inst.xbyte(8'h31, 1'b1, x, k);
    i2c_host_model_inst.xbyte(8'hFF, 1'b1, x, k);
    i2c_host_model_inst.stop();
    check_val("register", e, x);
  endtask
  // ********************
  // Scenarios.
  // ********************
  task automatic t_decode();
    apply(8'h23, 8'h0A, 1);
    check_cfg(2'h1, MHZ_533, MHZ_267, 1, 1, 1, 1, 0, 0, 3'h1, 2'h1);
    apply(8'h9B, 8'h02, 2);
    check_cfg(2'h2, MHZ_400, MHZ_267, 1, 1, 1, 1, 1, 0, 3'h0, 2'h0);
    apply(8'h71, 8'h45, 1);
    check_cfg(2'h3, MHZ_667, MHZ_333, 1, 0, 0, 0, 0, 1, 3'h2, 2'h2);
    apply(8'h01, 8'h02, 2);
    check_cfg(2'h0, MHZ_667, MHZ_333, 0, 1, 1, 1, 0, 0, 3'h0, 2'h0);
  endtask
  task automatic t_override();
    apply(8'hC3, 8'hEA, 2);
    reg_check(REG_POLARITY, 8'hF0);
    reg_check(REG_DIRECTION, 8'hFF);
    reg_check(REG_INPUT, 8'h32);
    reg_write(7'h19, REG_OUTPUT, 8'h00);
    reg_write(EXP_I2C_ADDR, REG_INPUT, 8'h00);
    reg_write(EXP_I2C_ADDR, REG_OUTPUT, 8'h10);
    reg_check(REG_OUTPUT, 8'h10);
    reg_write(EXP_I2C_ADDR, REG_DIRECTION, 8'hEF);
    reg_check(REG_INPUT, 8'h22);
    check_val("sda drive", 10'h000, sda_o);
    check_val("core before reset", MHZ_533, core);
    pulse(2);
    check_val("core overridden", MHZ_400, core);
    pulse(1);
    check_val("core kept", MHZ_400, core);
    reg_write(EXP_I2C_ADDR, REG_DIRECTION, 8'hED);
    pulse(2);
    check_val("bank overridden", 10'h000, fbk);
    reg_write(EXP_I2C_ADDR, REG_POLARITY, 8'h00);
    reg_check(REG_INPUT, 8'hD0);
    reg_write(EXP_I2C_ADDR, REG_DIRECTION, 8'hFF);
    pulse(2);
    check_val("core restored", MHZ_533, core);
    check_val("bank restored", 10'h001, fbk);
  endtask
  initial begin
    int n;
    repeat (5) @(posedge clock_i);
    resetn_i <= 1'b1;
    for (n = 0; n < 200 && !(por_n === 1'b1 && hrst_n === 1'b1); n++) @(posedge clock_i);
    if (n == 200) begin
      errors++;
      close_out();
    end
    check_cfg(2'h0, MHZ_533, MHZ_267, 1, 1, 1, 0, 1, 0, 3'h7, 2'h3);
    pulse(0);
    t_decode();
    t_override();
    close_out();
  end
endmodule
`default_nettype wire
